//--- spi_sw_regs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef SPI_SW_REGS_SVH
`define SPI_SW_REGS_SVH
`define ADDR_SW      7'h01
`define ADDR_CFG     7'h02
`define ADDR_FLAGS   7'h03
`define ADDR_BURST   7'h05
`define ADDR_SOFT    7'h0b
`define CFG_RST      3'h6
`define CFG_CRC      0
`define CFG_CLK      1
`define CFG_ADR      2
`define FLG_CRC      0
`define FLG_CLK      1
`define FLG_ADR      2
`define ALIGN_BYTE   8'h25
`define CLEAR_FRAME  16'h6ca9
`define DAISY_FRAME  16'h2500
`define SOFT_KEY1    8'ha3
`define SOFT_KEY2    8'h05
`define CRC_POLY     8'h07
`define POS_HDR      5'd8
`define POS_CHECK    5'd9
`define LEN_PLAIN    5'd16
`define LEN_CRC      5'd24
`define INIT_WAIT_US 120
`define CLK_MHZ      20
`define INIT_CYC     (`INIT_WAIT_US * `CLK_MHZ)
`endif

//--- spi_sw_pkg.sv
// Types shared by the serial switch control logic.
package spi_sw_pkg;
    typedef enum logic [0:0] {MODE_ADDR, MODE_DAISY} mode_t;
    typedef logic [7:0] byte_t;
    typedef logic [4:0] pos_t;
endpackage : spi_sw_pkg

//--- crc_if.sv
// Connection between the frame logic and the serial CRC engine.
`timescale 1ns/10ps
interface crc_if;
    logic       clr;
    logic       step;
    logic       din;
    logic [7:0] crc;
    logic [7:0] nxt;
    modport user   (output clr, step, din, input crc, nxt);
    modport engine (input clr, step, din, output crc, nxt);
endinterface : crc_if

//--- bit_sync.sv
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/10ps
module bit_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= RST_VAL;
            q        <= RST_VAL;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule : bit_sync

//--- crc8_serial.sv
// Bit-serial CRC-8 engine, most significant bit first.
`timescale 1ns/10ps
`include "spi_sw_regs.svh"
module crc8_serial #(
    parameter logic [7:0] POLY = `CRC_POLY
) (
    input wire logic clk,
    input wire logic rst,
    crc_if.engine    port
);
    always_comb begin
        port.nxt = {port.crc[6:0], 1'b0}
                 ^ ((port.crc[7] ^ port.din) ? POLY : 8'h00);
    end

    always_ff @(posedge clk) begin
        if (rst || port.clr) begin
            port.crc <= 8'h00;
        end else if (port.step) begin
            port.crc <= port.nxt;
        end
    end

    a_crc_seed_zero: assert property (@(posedge clk) disable iff (rst)
        port.clr |=> port.crc == 8'h00)
        else $error("CRC not seeded to zero");
endmodule : crc8_serial

//--- spi_sw_ctrl.sv
// Serial control interface of a quad switch with frame error checking.
`timescale 1ns/10ps
`include "spi_sw_regs.svh"
module spi_sw_ctrl (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          cs_n,
    input  wire logic          sclk,
    input  wire logic          sdi,
    output logic               sdo_o,
    output logic               sdo_oe,
    output logic [3:0]         sw_en,
    output logic               crc_en,
    output logic               sclk_err_en,
    output logic               addr_err_en,
    output logic [2:0]         err_flags,
    output logic               burst_en,
    output spi_sw_pkg::mode_t  link_mode,
    output logic               init_busy
);
    import spi_sw_pkg::*;

    localparam byte_t ALIGN = `ALIGN_BYTE;

    logic [2:0] pins_s;
    logic       cs_s;
    logic       sclk_s;
    logic       sdi_s;
    logic       cs_prev_reg;
    logic       sclk_prev_reg;
    logic       active;
    logic       cs_fall;
    logic       cs_rise;
    logic       rise;
    logic       fall;

    mode_t      mode_reg;
    pos_t       pos_reg;
    logic       cmds_reg;
    logic       over_reg;
    byte_t      shift_reg;
    byte_t      hdr_reg;
    byte_t      data_reg;
    logic       bad_reg;
    logic       defer_reg;
    byte_t      tx_reg;
    logic       sdo_reg;
    byte_t      dsr_reg;
    logic       key_reg;
    logic [3:0] sw_reg;
    logic [2:0] cfg_reg;
    logic [2:0] flags_reg;
    logic       burst_reg;
    logic [11:0] init_reg;

    pos_t       len;
    pos_t       pos_inc;
    byte_t      sh_next;
    byte_t      data_w;
    logic [15:0] word;
    logic       live;
    logic       at_hdr;
    logic       at_nine;
    logic       at_pay;
    logic       at_end;
    logic       wr;
    logic       crc_ok;
    logic       commit;
    logic       is_clear;
    logic       is_daisy;
    logic       bad_now;
    logic       clr_hit;
    logic       soft_hit;
    logic       cnt_bad;
    logic       hdr_ok;
    logic       special;
    byte_t      rd_val;
    logic [2:0] flag_set;

    crc_if crc_bus ();

    bit_sync #(.WIDTH(3), .RST_VAL(3'h4)) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({cs_n, sclk, sdi}),
        .q   (pins_s)
    );

    crc8_serial u_crc (
        .clk  (clk),
        .rst  (rst),
        .port (crc_bus.engine)
    );

    assign cs_s   = pins_s[2];
    assign sclk_s = pins_s[1];
    assign sdi_s  = pins_s[0];

    // Edges are found on the synchronised copies, so the serial clock must
    // stay well below a quarter of the system clock.
    always_ff @(posedge clk) begin
        if (rst) begin
            cs_prev_reg   <= 1'b1;
            sclk_prev_reg <= 1'b0;
        end else begin
            cs_prev_reg   <= cs_s;
            sclk_prev_reg <= sclk_s;
        end
    end

    assign active  = ~cs_s & ~cs_prev_reg;
    assign cs_fall = cs_prev_reg & ~cs_s;
    assign cs_rise = ~cs_prev_reg & cs_s;
    assign rise    = active & sclk_s & ~sclk_prev_reg;
    assign fall    = active & ~sclk_s & sclk_prev_reg;

    always_comb begin
        rd_val = 8'h00;
        hdr_ok = 1'b1;
        case (sh_next[6:0])
            `ADDR_SW:    rd_val = {4'h0, sw_reg};
            `ADDR_CFG:   rd_val = {5'h00, cfg_reg};
            `ADDR_FLAGS: begin
                rd_val = {5'h00, flags_reg};
                hdr_ok = sh_next[7];
            end
            `ADDR_BURST: rd_val = {7'h00, burst_reg};
            `ADDR_SOFT:  rd_val = 8'h00;
            default:     hdr_ok = 1'b0;
        endcase
    end

    always_comb begin
        len      = crc_en ? `LEN_CRC : `LEN_PLAIN;
        pos_inc  = pos_reg + 5'd1;
        sh_next  = {shift_reg[6:0], sdi_s};
        live     = rise & (mode_reg == MODE_ADDR)
                 & ~(cmds_reg & ~burst_reg);
        at_hdr   = live & (pos_inc == `POS_HDR);
        at_nine  = live & (pos_inc == `POS_CHECK);
        at_pay   = live & (pos_inc == `LEN_PLAIN);
        at_end   = live & (pos_inc == len);
        data_w   = crc_en ? data_reg : sh_next;
        word     = {hdr_reg, data_w};
        wr       = ~hdr_reg[7];
        crc_ok   = ~crc_en | (sh_next == crc_bus.crc);
        commit   = at_end & wr & crc_ok;
        is_clear = word == `CLEAR_FRAME;
        is_daisy = word == `DAISY_FRAME;
        special  = (sh_next == `CLEAR_FRAME >> 8)
                 | (sh_next == `DAISY_FRAME >> 8);
        bad_now  = bad_reg | (defer_reg & ~is_clear & ~is_daisy);
        clr_hit  = commit & is_clear;
        soft_hit = commit & ~bad_now & key_reg
                 & (hdr_reg[6:0] == `ADDR_SOFT)
                 & (data_w == `SOFT_KEY2);
        cnt_bad  = burst_reg ? (pos_reg != 5'd0)
                 : (~cmds_reg | over_reg | (pos_reg != 5'd0));
        flag_set = 3'h0;
        flag_set[`FLG_CRC] = at_end & wr & ~crc_ok;
        flag_set[`FLG_CLK] = cs_rise & (mode_reg == MODE_ADDR)
                           & sclk_err_en & cnt_bad;
        flag_set[`FLG_ADR] = addr_err_en & ((at_nine & bad_reg)
                           | (at_end & defer_reg & ~is_clear
                              & ~is_daisy));
    end

    // Only the first 16 bits feed the engine; the CRC byte is compared.
    assign crc_bus.clr  = cs_fall | at_end;
    assign crc_bus.step = live & (pos_reg < `LEN_PLAIN);
    assign crc_bus.din  = sdi_s;

    always_ff @(posedge clk) begin
        if (rst || cs_fall) begin
            pos_reg   <= 5'd0;
            cmds_reg  <= 1'b0;
            over_reg  <= 1'b0;
            shift_reg <= 8'h00;
            bad_reg   <= 1'b0;
            defer_reg <= 1'b0;
        end else if (rise) begin
            shift_reg <= sh_next;
            if (!live) begin
                over_reg <= 1'b1;
            end else if (at_end) begin
                pos_reg  <= 5'd0;
                cmds_reg <= 1'b1;
            end else begin
                pos_reg <= pos_inc;
            end
            if (at_hdr) begin
                bad_reg   <= ~hdr_ok & ~special;
                defer_reg <= special;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hdr_reg  <= 8'h00;
            data_reg <= 8'h00;
        end else begin
            if (at_hdr) begin
                hdr_reg <= sh_next;
            end
            if (at_pay) begin
                data_reg <= sh_next;
            end
        end
    end

    // Output shifter: in address mode tx_reg[7] goes out on the next falling edge; in daisy mode dsr_reg[7] does.
    always_ff @(posedge clk) begin
        if (rst || cs_s) begin
            tx_reg  <= 8'hff;
            sdo_reg <= 1'b1;
        end else if (cs_fall) begin
            tx_reg  <= {ALIGN[6:0], 1'b1};
            sdo_reg <= (mode_reg == MODE_DAISY) ? dsr_reg[7] : ALIGN[7];
        end else if (mode_reg == MODE_DAISY) begin
            if (fall) begin
                sdo_reg <= dsr_reg[7];
            end
        end else if (fall) begin
            sdo_reg <= tx_reg[7];
            tx_reg  <= {tx_reg[6:0], 1'b1};
        end else if (at_hdr) begin
            tx_reg <= sh_next[7] ? rd_val : 8'h00;
        end else if (at_pay && crc_en) begin
            tx_reg <= hdr_reg[7] ? crc_bus.nxt : 8'h00;
        end else if (at_end) begin
            tx_reg <= burst_reg ? ALIGN : 8'hff;
        end
    end

    assign sdo_o  = 1'b0;
    assign sdo_oe = ~sdo_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg <= MODE_ADDR;
            dsr_reg  <= 8'h00;
        end else if (mode_reg == MODE_ADDR) begin
            if (commit && is_daisy) begin
                mode_reg <= MODE_DAISY;
                dsr_reg  <= 8'h00;
            end
        end else if (rise) begin
            dsr_reg <= {dsr_reg[6:0], sdi_s};
        end
    end

    always_ff @(posedge clk) begin
        if (rst || soft_hit) begin
            sw_reg    <= 4'h0;
            cfg_reg   <= `CFG_RST;
            burst_reg <= 1'b0;
        end else if (mode_reg == MODE_DAISY) begin
            if (cs_rise) begin
                sw_reg <= dsr_reg[3:0];
            end
        end else if (commit && !bad_now) begin
            case (hdr_reg[6:0])
                `ADDR_SW:    sw_reg    <= data_w[3:0];
                `ADDR_CFG:   cfg_reg   <= data_w[2:0];
                `ADDR_BURST: burst_reg <= data_w[0];
                default:     ;
            endcase
        end
    end

    // A software reset returns the flags to zero, yet a fresh event wins.
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_reg <= 3'h0;
        end else if (soft_hit) begin
            flags_reg <= flag_set;
        end else begin
            flags_reg <= (flags_reg & ~{3{clr_hit}}) | flag_set;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || soft_hit) begin
            key_reg <= 1'b0;
        end else if (at_end) begin
            key_reg <= commit & ~bad_now & (data_w == `SOFT_KEY1)
                     & (hdr_reg[6:0] == `ADDR_SOFT);
        end
    end

    // Commands are not refused while busy; the host is trusted to wait.
    always_ff @(posedge clk) begin
        if (rst || soft_hit) begin
            init_reg <= 12'(`INIT_CYC);
        end else if (init_reg != 12'h000) begin
            init_reg <= init_reg - 12'h001;
        end
    end

    assign sw_en       = sw_reg;
    assign crc_en      = cfg_reg[`CFG_CRC];
    assign sclk_err_en = cfg_reg[`CFG_CLK];
    assign addr_err_en = cfg_reg[`CFG_ADR];
    assign err_flags   = flags_reg;
    assign burst_en    = burst_reg;
    assign link_mode   = mode_reg;
    assign init_busy   = init_reg != 12'h000;

    a_align_start: assert property (@(posedge clk) disable iff (rst)
        cs_fall && mode_reg == MODE_ADDR
        |=> sdo_reg == ALIGN[7] && tx_reg == {ALIGN[6:0], 1'b1})
        else $error("Alignment byte not loaded at frame start");

    a_sdo_on_fall: assert property (@(posedge clk) disable iff (rst)
        $changed(sdo_reg) && $past(active) |-> $past(fall))
        else $error("Output changed away from a falling edge");

    a_crc_blocks: assert property (@(posedge clk) disable iff (rst)
        at_end && crc_en && wr && !crc_ok
        |=> flags_reg[`FLG_CRC] && $stable(sw_reg) && $stable(cfg_reg))
        else $error("Bad CRC write was not blocked");

    a_write_lands: assert property (@(posedge clk) disable iff (rst)
        commit && !bad_now && hdr_reg[6:0] == `ADDR_SW
        |-> pos_inc == (crc_en ? `LEN_CRC : `LEN_PLAIN)
            ##1 sw_reg == $past(data_w[3:0]))
        else $error("Switch write at wrong edge or value");

    a_short_frame: assert property (@(posedge clk) disable iff (rst)
        cs_rise && !cmds_reg && mode_reg == MODE_ADDR
        |=> $stable(sw_reg) && $stable(cfg_reg) && $stable(burst_reg))
        else $error("Short frame changed a register");

    a_count_flag: assert property (@(posedge clk) disable iff (rst)
        cs_rise && mode_reg == MODE_ADDR && sclk_err_en
        && pos_reg != 5'd0 |=> flags_reg[`FLG_CLK])
        else $error("Clock-count error not flagged");

    a_cfg_default: assert property (@(posedge clk) disable iff (rst)
        $fell(rst) |-> cfg_reg == `CFG_RST && !crc_en)
        else $error("Error configuration wrong after reset");

    a_addr_flag: assert property (@(posedge clk) disable iff (rst)
        at_nine && bad_reg && addr_err_en |=> flags_reg[`FLG_ADR])
        else $error("Invalid address not flagged at ninth edge");

    a_clear_flags: assert property (@(posedge clk) disable iff (rst)
        clr_hit |=> flags_reg == 3'h0)
        else $error("Clear frame left flags set");

    a_soft_reset: assert property (@(posedge clk) disable iff (rst)
        soft_hit |=> cfg_reg == `CFG_RST && sw_reg == 4'h0 && init_busy)
        else $error("Software reset did not restore defaults");

    a_daisy_hold: assert property (@(posedge clk) disable iff (rst)
        mode_reg == MODE_DAISY |=> mode_reg == MODE_DAISY [*4])
        else $error("Daisy mode left without hardware reset");

    a_daisy_load: assert property (@(posedge clk) disable iff (rst)
        mode_reg == MODE_DAISY && cs_rise
        |=> sw_reg == $past(dsr_reg[3:0]))
        else $error("Daisy byte not loaded at chip-select rise");
endmodule : spi_sw_ctrl

//--- spi_host_model.sv
// Behavioural host controller that drives the switch link in clock mode 0.
`timescale 1ns/10ps
module spi_host_model (
    input  wire logic clk,
    input  wire logic sdo_line,
    output logic      cs_n,
    output logic      sclk,
    output logic      sdi
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi  = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_cyc

    // Sends the low nbits of tx, most significant first; each half period
    // is four system clocks, so the link clock runs at 400 ns.
    task automatic xfer(input int nbits, input logic [47:0] tx,
                        output logic [47:0] rx);
        rx = '0;
        @(posedge clk);
        cs_n <= 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            sdi <= tx[i];
            wait_cyc(4);
            sclk <= 1'b1;
            wait_cyc(4);
            // Sampled late in the high phase, well clear of the next fall.
            rx = {rx[46:0], sdo_line};
            sclk <= 1'b0;
        end
        wait_cyc(4);
        cs_n <= 1'b1;
        // A released data line must not keep looking like the last bit.
        sdi <= ~sdi;
        wait_cyc(8);
    endtask : xfer
endmodule : spi_host_model

//--- spi_sw_ctrl_tb.sv
// Self-checking bench for the serial switch control block.
`timescale 1ns/10ps
module spi_sw_ctrl_tb;
    import spi_sw_pkg::*;
    logic        clk;
    logic        rst;
    logic        cs_n;
    logic        sclk;
    logic        sdi;
    logic        sdo_o;
    logic        sdo_oe;
    logic [3:0]  sw_en;
    logic        crc_en;
    logic        sclk_err_en;
    logic        addr_err_en;
    logic [2:0]  err_flags;
    logic        burst_en;
    mode_t       link_mode;
    logic        init_busy;
    logic        sdo_line;
    logic [47:0] rx;
    int          num_errors = 0;
    int          num_checks = 0;

    // The data line has a pull-up; the device only ever pulls it low.
    assign sdo_line = sdo_oe ? sdo_o : 1'b1;

    spi_sw_ctrl i_dut (.clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk),
        .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .sw_en(sw_en),
        .crc_en(crc_en), .sclk_err_en(sclk_err_en),
        .addr_err_en(addr_err_en), .err_flags(err_flags),
        .burst_en(burst_en), .link_mode(link_mode), .init_busy(init_busy));

    spi_host_model i_host (.clk(clk), .sdo_line(sdo_line), .cs_n(cs_n),
        .sclk(sclk), .sdi(sdi));

    initial clk = 1'b0;
    always #25 clk = ~clk;

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction : crc8

    task automatic cmd(input int n, input logic [47:0] tx);
        i_host.xfer(n, tx, rx);
    endtask : cmd

    task automatic cmd_crc(input logic [15:0] tx, input logic [7:0] flip);
        cmd(24, {24'h0, tx, crc8(tx) ^ flip});
    endtask : cmd_crc

    task automatic do_reset;
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
    endtask : do_reset

    // The host keeps off the link until initialisation has finished.
    task automatic wait_ready;
        int n;
        n = 0;
        while (init_busy !== 1'b0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        check("init wait long", 1, n > 2300);
        check("init_busy", 0, init_busy);
    endtask : wait_ready

    task automatic t_reset_values;
        do_reset();
        @(posedge clk);
        check("sw_en", 4'h0, sw_en);
        check("crc_en", 0, crc_en);
        check("sclk_err_en", 1, sclk_err_en);
        check("addr_err_en", 1, addr_err_en);
        check("err_flags", 3'h0, err_flags);
        check("link_mode", MODE_ADDR, link_mode);
        wait_ready();
    endtask : t_reset_values

    task automatic t_write_read;
        cmd(16, 16'h0105);
        check("write echo", 16'h2500, rx[15:0]);
        check("sw_en", 4'h5, sw_en);
        cmd(16, 16'h8100);
        check("read data", 16'h2505, rx[15:0]);
        check("err_flags", 3'h0, err_flags);
    endtask : t_write_read

    task automatic t_count_errors;
        cmd(12, 12'h010);
        check("short sw_en", 4'h5, sw_en);
        check("short flag", 3'h2, err_flags);
        cmd(16, 16'h6ca9);
        check("cleared", 3'h0, err_flags);
        cmd(20, 20'h01030);
        check("long sw_en", 4'h3, sw_en);
        check("long flag", 3'h2, err_flags);
        cmd(16, 16'h6ca9);
    endtask : t_count_errors

    task automatic t_bad_address;
        cmd(16, 16'h0307);
        check("ro flag", 3'h4, err_flags);
        cmd(16, 16'h6ca9);
        cmd(16, 16'h7f0a);
        check("none flag", 3'h4, err_flags);
        check("none sw_en", 4'h3, sw_en);
        cmd(16, 16'h6ca9);
        check("clear no flag", 3'h0, err_flags);
        // With both checks switched off, bad frames must leave no flag.
        cmd(16, 16'h0200);
        check("checks off", 2'h0, {sclk_err_en, addr_err_en});
        cmd(12, 12'h010);
        cmd(16, 16'h7f0a);
        check("off flags", 3'h0, err_flags);
        check("off sw_en", 4'h3, sw_en);
        cmd(16, 16'h0206);
        check("checks on", 2'h3, {sclk_err_en, addr_err_en});
    endtask : t_bad_address

    task automatic t_crc;
        cmd(16, 16'h0207);
        check("crc_en", 1, crc_en);
        cmd_crc(16'h0109, 8'h00);
        check("crc write", 4'h9, sw_en);
        check("crc flags", 3'h0, err_flags);
        cmd_crc(16'h010f, 8'h01);
        check("bad crc sw_en", 4'h9, sw_en);
        check("bad crc flag", 3'h1, err_flags);
        cmd_crc(16'h8100, 8'h00);
        check("crc read", {8'h25, 8'h09, crc8(16'h8100)}, rx[23:0]);
        cmd_crc(16'h6ca9, 8'h00);
        check("crc clear", 3'h0, err_flags);
        cmd_crc(16'h0206, 8'h00);
        check("crc off", 0, crc_en);
    endtask : t_crc

    task automatic t_burst;
        cmd(16, 16'h0501);
        check("burst_en", 1, burst_en);
        cmd(32, 32'h0106_8100);
        check("burst replies", 32'h2500_2506, rx[31:0]);
        check("burst flags", 3'h0, err_flags);
        cmd(24, 24'h0101_00);
        check("burst part sw", 4'h1, sw_en);
        check("burst part flag", 3'h2, err_flags);
        cmd(16, 16'h6ca9);
    endtask : t_burst

    task automatic t_soft_reset;
        cmd(16, 16'h0ba3);
        check("key one only", 4'h1, sw_en);
        cmd(16, 16'h0b05);
        check("soft sw_en", 4'h0, sw_en);
        check("soft burst", 0, burst_en);
        check("soft busy", 1, init_busy);
        wait_ready();
    endtask : t_soft_reset

    task automatic t_daisy;
        cmd(16, 16'h2500);
        check("daisy echo", 16'h2500, rx[15:0]);
        check("daisy mode", MODE_DAISY, link_mode);
        cmd(16, 16'h0203);
        check("daisy first", 16'h0002, rx[15:0]);
        check("daisy sw", 4'h3, sw_en);
        check("daisy no cfg", 0, crc_en);
        cmd(8, 8'h0c);
        check("daisy kept", 8'h03, rx[7:0]);
        cmd(12, 12'h5a7);
        check("daisy odd out", 12'h0c5, rx[11:0]);
        check("daisy odd sw", 4'h7, sw_en);
        do_reset();
        @(posedge clk);
        check("daisy exit", MODE_ADDR, link_mode);
    endtask : t_daisy

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    initial begin
        rst = 1'b1;
        t_reset_values();
        t_write_read();
        t_count_errors();
        t_bad_address();
        t_crc();
        t_burst();
        t_soft_reset();
        t_daisy();
        report_and_stop();
    end

    // Two init waits and a few dozen frames stay far below this span.
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end
endmodule : spi_sw_ctrl_tb
